// [core/rbsc_agent.sv]
`default_nettype none
module rbsc_agent #(
    parameter int unsigned SETTLE_CYC = rbsc_pkg::SUPPLY_SETTLE_CYC
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // link to the device
    rbsc_if.agent_mp link,
    // system side
    input wire logic supply_in_range,
    input wire logic cold_req,
    input wire logic warm_req,
    input wire logic [rbsc_pkg::MODE_DEF_W-1:0] mode_word,
    input wire logic [rbsc_pkg::GEN_INT_W-1:0] int_req,
    input wire logic nmi_req,
    input wire logic ext_req,
    // status
    output logic link_up
);
    typedef struct packed {
        rbsc_pkg::rbsc_agent_state_e st;
        logic [23:0] settle_cnt;
        logic [7:0] hold_cnt;
        logic [8:0] bit_idx;
        logic sg;
        logic cold_n;
        logic warm_n;
        logic cold_pend;
        logic mdat;
        logic mclk_prev;
        logic mout_prev;
        logic [rbsc_pkg::GEN_INT_W-1:0] int_n;
        logic nmi_n;
        logic ext_n;
    } rbsc_agent_s;

    rbsc_agent_s s;
    rbsc_agent_s next_s;
    logic master_q;
    logic mode_fall;
    logic mout_rise;

    function automatic logic stream_bit(input logic [rbsc_pkg::MODE_DEF_W-1:0] w,
                                        input logic [8:0] idx);
        // undefined positions must be zero
        stream_bit = (idx < 9'(rbsc_pkg::MODE_DEF_W)) ? w[idx[4:0]] : 1'b0;
    endfunction

    rbsc_clkdiv #(
        .HALF(rbsc_pkg::MASTER_HALF),
        .CW(1)
    ) u_master (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .run(1'b1),
        .clk_o(master_q),
        .rise()
    );

    always_comb begin
        next_s = s;
        mode_fall = s.mclk_prev && !link.mode_clk;
        mout_rise = !s.mout_prev && link.master_clk_out;
        next_s.mclk_prev = link.mode_clk;
        next_s.mout_prev = link.master_clk_out;
        next_s.int_n = ~int_req;
        next_s.nmi_n = ~nmi_req;
        next_s.ext_n = ~ext_req;
        if (!supply_in_range) begin
            next_s.st = rbsc_pkg::AG_OFF;
            next_s.sg = 1'b0;
            next_s.cold_n = 1'b0;
            next_s.warm_n = 1'b0;
        end else begin
            case (s.st)
                rbsc_pkg::AG_OFF: begin
                    next_s.st = rbsc_pkg::AG_SETTLE;
                    next_s.settle_cnt = '0;
                end
                rbsc_pkg::AG_SETTLE: begin
                    next_s.settle_cnt = 24'(s.settle_cnt + 1'b1);
                    if (s.settle_cnt == 24'(SETTLE_CYC - 1)) begin
                        next_s.st = rbsc_pkg::AG_STREAM;
                        next_s.sg = 1'b1;
                        next_s.bit_idx = '0;
                        next_s.mdat = stream_bit(mode_word, 9'h000);
                    end
                end
                rbsc_pkg::AG_STREAM: begin
                    if (mode_fall) begin
                        next_s.bit_idx = 9'(s.bit_idx + 1'b1);
                        next_s.mdat = stream_bit(mode_word, 9'(s.bit_idx + 1'b1));
                        if (s.bit_idx == rbsc_pkg::STREAM_LAST) begin
                            next_s.st = rbsc_pkg::AG_REL_COLD;
                            next_s.mdat = 1'b0;
                        end
                    end
                end
                rbsc_pkg::AG_REL_COLD: begin
                    if (mout_rise) begin
                        next_s.cold_n = 1'b1;
                        next_s.st = rbsc_pkg::AG_REL_WARM;
                    end
                end
                rbsc_pkg::AG_REL_WARM: begin
                    if (mout_rise) begin
                        next_s.warm_n = 1'b1;
                        next_s.st = rbsc_pkg::AG_RUN;
                    end
                end
                rbsc_pkg::AG_RUN: begin
                    if (cold_req || warm_req) begin
                        next_s.st = rbsc_pkg::AG_HOLD;
                        next_s.hold_cnt = '0;
                        next_s.cold_pend = cold_req;
                        next_s.cold_n = !cold_req;
                        next_s.warm_n = 1'b0;
                    end
                end
                rbsc_pkg::AG_HOLD: begin
                    next_s.hold_cnt = 8'(s.hold_cnt + 1'b1);
                    if (s.hold_cnt == rbsc_pkg::RST_HOLD_LAST) begin
                        next_s.st = s.cold_pend ? rbsc_pkg::AG_REL_COLD
                                                : rbsc_pkg::AG_REL_WARM;
                    end
                end
                default: begin
                    next_s.st = rbsc_pkg::AG_OFF;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            s <= '{st: rbsc_pkg::AG_OFF, int_n: '1, nmi_n: 1'b1, ext_n: 1'b1, default: '0};
        end else begin
            s <= next_s;
        end
    end

    assign link.supply_good = s.sg;
    assign link.power_on_rst_n = s.cold_n;
    assign link.warm_rst_n = s.warm_n;
    assign link.mode_data = s.mdat;
    assign link.int_n = s.int_n;
    assign link.nmi_n = s.nmi_n;
    assign link.external_request_n = s.ext_n;
    assign link.master_clk_in = master_q;
    assign link_up = (s.st == rbsc_pkg::AG_RUN);
endmodule // rbsc_agent
`default_nettype wire

// [core/rbsc_clkdiv.sv]
`default_nettype none
module rbsc_clkdiv #(
    parameter int unsigned HALF = 1,
    parameter int unsigned CW = 1
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // control
    input wire logic run,
    // divided clock
    output logic clk_o,
    output logic rise
);
    typedef struct packed {
        logic [CW-1:0] cnt;
        logic clk;
    } rbsc_div_s;

    rbsc_div_s s;
    rbsc_div_s next_s;
    logic tick;

    always_comb begin
        next_s = s;
        tick = run && (s.cnt == CW'(HALF - 1));
        // held low while stopped so it restarts on a fresh half period
        if (!run) begin
            next_s.cnt = '0;
            next_s.clk = 1'b0;
        end else if (tick) begin
            next_s.cnt = '0;
            next_s.clk = ~s.clk;
        end else begin
            next_s.cnt = CW'(s.cnt + 1'b1);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign clk_o = s.clk;
    assign rise = tick && !s.clk;
endmodule // rbsc_clkdiv
`default_nettype wire

// [core/rbsc_device.sv]
`default_nettype none
module rbsc_device (
    // clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // link to the agent
    rbsc_if.device_mp link,
    // core side
    input wire logic wait_exec,
    input wire logic bus_idle,
    input wire logic [rbsc_pkg::TIMER_W-1:0] timer_compare,
    input wire logic timer_ack,
    // status
    output logic [rbsc_pkg::INT_W-1:0] int_reg,
    output logic core_clk_en,
    output logic standby,
    output logic int_enable,
    output logic in_reset,
    output logic boot_done,
    output logic timer_int_disabled
);
    typedef struct packed {
        rbsc_pkg::rbsc_dev_state_e st;
        logic [rbsc_pkg::INT_W-1:0] int_reg;
        logic [rbsc_pkg::TIMER_W-1:0] timer_cnt;
        logic timer_pend;
        logic tmr_dis;
        logic [8:0] boot_cnt;
        logic boot_active;
        logic boot_done;
        logic boot_tail;
        logic sg_prev;
        logic int_en;
        logic clk_en;
        logic in_reset;
        logic mclk_out;
        logic stby;
    } rbsc_dev_s;

    rbsc_dev_s s;
    rbsc_dev_s next_s;
    logic [rbsc_pkg::INT_W-1:0] irq;
    logic sys_clk_q;
    logic mode_clk_q;
    logic mode_rise;
    logic any_rst;

    // system clock runs only while the cold reset is released
    rbsc_clkdiv #(
        .HALF(rbsc_pkg::SYS_HALF),
        .CW(1)
    ) u_sysdiv (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .run(link.power_on_rst_n),
        .clk_o(sys_clk_q),
        .rise()
    );

    // mode clock runs only while the boot stream is active; standby does not gate it
    rbsc_clkdiv #(
        .HALF(rbsc_pkg::MODE_HALF),
        .CW(8)
    ) u_modediv (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .run(s.boot_active),
        .clk_o(mode_clk_q),
        .rise(mode_rise)
    );

    always_comb begin
        next_s = s;
        any_rst = !link.power_on_rst_n || !link.warm_rst_n;
        // pins are sampled every cycle, standby included
        irq = {~link.nmi_n, ~link.int_n};
        if (s.timer_pend && !s.tmr_dis) begin
            irq[rbsc_pkg::TIMER_INT_POS] = 1'b1;
        end
        next_s.int_reg = irq;
        next_s.mclk_out = link.master_clk_in;

        // timer never stops; set wins over acknowledge
        next_s.timer_cnt = rbsc_pkg::TIMER_W'(s.timer_cnt + 1'b1);
        if (timer_ack) begin
            next_s.timer_pend = 1'b0;
        end
        if (s.timer_cnt == timer_compare) begin
            next_s.timer_pend = 1'b1;
        end

        // boot stream
        next_s.sg_prev = link.supply_good;
        if (link.supply_good && !s.sg_prev) begin
            next_s.boot_active = 1'b1;
            next_s.boot_tail = 1'b0;
            next_s.boot_cnt = '0;
            next_s.boot_done = 1'b0;
        end else if (!link.supply_good) begin
            next_s.boot_active = 1'b0;
            next_s.boot_tail = 1'b0;
        end else if (s.boot_tail) begin
            // last high phase runs out whole; a cut would shorten the period
            if (!mode_clk_q) begin
                next_s.boot_active = 1'b0;
                next_s.boot_tail = 1'b0;
            end
        end else if (s.boot_active && mode_rise) begin
            // agent shifts on the falling edge, so data is settled here
            if (s.boot_cnt == rbsc_pkg::TIMER_DIS_POS) begin
                next_s.tmr_dis = link.mode_data;
            end
            next_s.boot_cnt = 9'(s.boot_cnt + 1'b1);
            if (s.boot_cnt == rbsc_pkg::STREAM_LAST) begin
                next_s.boot_tail = 1'b1;
                next_s.boot_done = 1'b1;
            end
        end

        // power state
        next_s.in_reset = any_rst;
        if (any_rst) begin
            next_s.st = rbsc_pkg::DEV_RESET;
            next_s.clk_en = 1'b1;
            next_s.int_en = 1'b0;
        end else begin
            case (s.st)
                rbsc_pkg::DEV_RESET: begin
                    next_s.st = rbsc_pkg::DEV_RUN;
                end
                rbsc_pkg::DEV_RUN: begin
                    if (wait_exec) begin
                        next_s.int_en = 1'b1;
                        if (bus_idle) begin
                            next_s.st = rbsc_pkg::DEV_STANDBY;
                            next_s.clk_en = 1'b0;
                        end
                        // busy bus: wait only sets int_en and stays in DEV_RUN
                    end
                end
                rbsc_pkg::DEV_STANDBY: begin
                    // wake does not look at the mask, only at pending lines
                    if (|irq) begin
                        next_s.st = rbsc_pkg::DEV_RUN;
                        next_s.clk_en = 1'b1;
                    end
                end
                default: begin
                    next_s.st = rbsc_pkg::DEV_RESET;
                end
            endcase
        end
        // flop copy keeps the standby pin free of decode glitches
        next_s.stby = (next_s.st == rbsc_pkg::DEV_STANDBY);
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            s <= '{
                st: rbsc_pkg::DEV_RESET,
                clk_en: 1'b1,
                in_reset: 1'b1,
                default: '0
            };
        end else begin
            s <= next_s;
        end
    end

    // all clock outputs come from divider or sample flops; system and mode clocks stop when their divider run drops
    assign link.system_clk_internal = sys_clk_q;
    assign link.transmit_clk_out = {2{sys_clk_q}};
    assign link.receive_clk_out = {2{sys_clk_q}};
    assign link.sync_clk_out = sys_clk_q;
    assign link.mode_clk = mode_clk_q;
    assign link.master_clk_out = s.mclk_out;

    assign int_reg = s.int_reg;
    assign core_clk_en = s.clk_en;
    assign standby = s.stby;
    assign int_enable = s.int_en;
    assign in_reset = s.in_reset;
    assign boot_done = s.boot_done;
    assign timer_int_disabled = s.tmr_dis;
endmodule // rbsc_device
`default_nettype wire

// [core/rbsc_if.sv]
`default_nettype none
interface rbsc_if;
    // agent to device
    logic supply_good;
    logic power_on_rst_n;
    logic warm_rst_n;
    logic mode_data;
    logic [rbsc_pkg::GEN_INT_W-1:0] int_n;
    logic nmi_n;
    logic external_request_n;
    logic master_clk_in;
    // device to agent
    logic mode_clk;
    logic master_clk_out;
    logic system_clk_internal;
    logic [1:0] transmit_clk_out;
    logic [1:0] receive_clk_out;
    logic sync_clk_out;

    modport device_mp (
        input supply_good, power_on_rst_n, warm_rst_n, mode_data, int_n, nmi_n,
        input external_request_n, master_clk_in,
        output mode_clk, master_clk_out, system_clk_internal, transmit_clk_out,
        output receive_clk_out, sync_clk_out
    );
    modport agent_mp (
        output supply_good, power_on_rst_n, warm_rst_n, mode_data, int_n, nmi_n,
        output external_request_n, master_clk_in,
        input mode_clk, master_clk_out, system_clk_internal, transmit_clk_out,
        input receive_clk_out, sync_clk_out
    );
endinterface
`default_nettype wire

// [core/rbsc_pkg.sv]
`default_nettype none
package rbsc_pkg;
    // time base
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned SUPPLY_SETTLE_MS = 100;
    localparam int unsigned SUPPLY_SETTLE_CYC = (SUPPLY_SETTLE_MS * 1000000) / CLK_PERIOD_NS;
    // clock ratios, in sys_clk cycles per half period
    localparam int unsigned SYS_HALF = 1;
    localparam int unsigned MODE_DIV = 256;
    localparam int unsigned MODE_HALF = SYS_HALF * MODE_DIV;
    localparam int unsigned MASTER_HALF = 1;
    // boot stream
    localparam int unsigned STREAM_LEN = 256;
    localparam logic [8:0] STREAM_LAST = 9'h0FF;
    localparam int unsigned MODE_DEF_W = 19;
    localparam logic [8:0] TIMER_DIS_POS = 9'h00B;
    // interrupt register layout
    localparam int unsigned GEN_INT_W = 6;
    localparam int unsigned INT_W = 7;
    localparam int unsigned NMI_POS = 6;
    localparam int unsigned TIMER_INT_POS = 5;
    localparam int unsigned TIMER_W = 16;
    // agent reset hold for a requested cold or warm reset
    localparam logic [7:0] RST_HOLD_LAST = 8'h0F;

    typedef enum logic [1:0] {
        DEV_RESET = 2'b00,
        DEV_RUN = 2'b01,
        DEV_STANDBY = 2'b11
    } rbsc_dev_state_e;

    typedef enum logic [2:0] {
        AG_OFF = 3'b000,
        AG_SETTLE = 3'b001,
        AG_STREAM = 3'b011,
        AG_REL_COLD = 3'b010,
        AG_REL_WARM = 3'b110,
        AG_RUN = 3'b111,
        AG_HOLD = 3'b101
    } rbsc_agent_state_e;
endpackage
`default_nettype wire

// [tb/rbsc_monitor.sv]
`default_nettype none
module rbsc_monitor (
    // clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // agent to device
    input wire logic supply_good,
    input wire logic power_on_rst_n,
    input wire logic warm_rst_n,
    input wire logic mode_data,
    input wire logic master_clk_in,
    // device to agent
    input wire logic mode_clk,
    input wire logic master_clk_out,
    input wire logic system_clk_internal,
    input wire logic [1:0] transmit_clk_out,
    input wire logic [1:0] receive_clk_out,
    input wire logic sync_clk_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // cycles spent high in the current mode clock phase
    logic [9:0] hi_cnt;
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            hi_cnt <= 10'h000;
        end else begin
            hi_cnt <= mode_clk ? hi_cnt + 10'h001 : 10'h000;
        end
    end
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!nrst);
    property p_master_follow;
        $past(nrst) |-> master_clk_out == $past(master_clk_in);
    endproperty
    a_master_follow: assert property (p_master_follow) else $error("master out lag");
    // pin may pass a sync flop first, so two settled samples are required
    property p_clk_run;
        $past(nrst, 2) && power_on_rst_n && $past(power_on_rst_n) && $past(power_on_rst_n, 2)
            |-> system_clk_internal != $past(system_clk_internal);
    endproperty
    a_clk_run: assert property (p_clk_run) else $error("system clock stuck");
    property p_clk_low;
        !power_on_rst_n && !$past(power_on_rst_n) && !$past(power_on_rst_n, 2)
            |-> !system_clk_internal;
    endproperty
    a_clk_low: assert property (p_clk_low) else $error("clock runs in cold reset");
    property p_clk_same;
        {transmit_clk_out, receive_clk_out, sync_clk_out} == {5{system_clk_internal}};
    endproperty
    a_clk_same: assert property (p_clk_same) else $error("clock outputs differ");
    property p_mode_half;
        $fell(mode_clk) && supply_good |-> hi_cnt == 10'h100;
    endproperty
    a_mode_half: assert property (p_mode_half) else $error("mode clock half period");
    property p_mode_gate;
        !supply_good && !$past(supply_good) |-> !mode_clk;
    endproperty
    a_mode_gate: assert property (p_mode_gate) else $error("mode clock without supply");
    property p_data_hold;
        supply_good && $past(supply_good) && $changed(mode_data) |-> !mode_clk;
    endproperty
    a_data_hold: assert property (p_data_hold) else $error("mode data moved");
    property p_cold_rel;
        $rose(power_on_rst_n) |-> !warm_rst_n && supply_good;
    endproperty
    a_cold_rel: assert property (p_cold_rel) else $error("cold release order");
    property p_warm_rel;
        $rose(power_on_rst_n) |-> ##[1:4] $rose(warm_rst_n);
    endproperty
    a_warm_rel: assert property (p_warm_rel) else $error("warm release late");
    property p_warm_cold;
        $rose(warm_rst_n) |-> power_on_rst_n;
    endproperty
    a_warm_cold: assert property (p_warm_cold) else $error("warm before cold");
endmodule // rbsc_monitor
`default_nettype wire

// [tb/reset_boot_standby_control_tb_top.sv]
`default_nettype none
module reset_boot_standby_control_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic wait_exec = 1'b0;
    logic bus_idle = 1'b0;
    logic timer_ack = 1'b0;
    logic supply_in_range = 1'b0;
    logic cold_req = 1'b0;
    logic warm_req = 1'b0;
    logic nmi_req = 1'b0;
    logic ext_req = 1'b0;
    // bit 11 set: timer kept off line 5 so int_reg checks stay exact
    logic [18:0] mode_word = 19'h58A5;
    logic [5:0] int_req = 6'h00;
    logic [6:0] int_reg;
    logic core_clk_en, standby, int_enable, in_reset, boot_done, timer_int_disabled, link_up;
    int failures = 0;
    int cmp_count = 0;
    rbsc_if link ();
    always #5 sys_clk = ~sys_clk;
    rbsc_device u_rbsc_device (.sys_clk(sys_clk), .nrst(nrst), .link(link.device_mp),
        .wait_exec(wait_exec), .bus_idle(bus_idle), .timer_compare(16'hFFFF),
        .timer_ack(timer_ack), .int_reg(int_reg), .core_clk_en(core_clk_en),
        .standby(standby), .int_enable(int_enable), .in_reset(in_reset),
        .boot_done(boot_done), .timer_int_disabled(timer_int_disabled));
    rbsc_agent #(.SETTLE_CYC(20)) u_rbsc_agent (.sys_clk(sys_clk), .nrst(nrst),
        .link(link.agent_mp), .supply_in_range(supply_in_range), .cold_req(cold_req),
        .warm_req(warm_req), .mode_word(mode_word), .int_req(int_req), .nmi_req(nmi_req),
        .ext_req(ext_req), .link_up(link_up));
    rbsc_monitor u_rbsc_monitor (.sys_clk(sys_clk), .nrst(nrst),
        .supply_good(link.supply_good), .power_on_rst_n(link.power_on_rst_n),
        .warm_rst_n(link.warm_rst_n), .mode_data(link.mode_data),
        .master_clk_in(link.master_clk_in), .mode_clk(link.mode_clk),
        .master_clk_out(link.master_clk_out), .system_clk_internal(link.system_clk_internal),
        .transmit_clk_out(link.transmit_clk_out), .receive_clk_out(link.receive_clk_out),
        .sync_clk_out(link.sync_clk_out));
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("BAD %s exp %h got %h", what, exp, got);
        end
    endtask
    task automatic stop_test();
        $display("compares %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    function automatic logic sel(input int w);
        case (w)
            0: return link_up;
            1: return standby;
            default: return in_reset;
        endcase
    endfunction
    task automatic wait_on(input int w, input logic want, input int lim);
        int n = 0;
        while (sel(w) !== want && n < lim) begin
            @(negedge sys_clk);
            n++;
        end
        if (sel(w) !== want) begin
            failures++;
            $display("BAD wait %0d exp %b got %b", w, want, sel(w));
            stop_test();
        end
    endtask
    initial begin
        int idx;
        logic prev;
        idx = 0;
        prev = 1'b0;
        cyc(3);
        nrst = 1'b1;
        supply_in_range = 1'b1;
        // the stream alone is 256 periods of 512 cycles
        for (int n = 0; n < 140000 && link_up !== 1'b1; n++) begin
            @(negedge sys_clk);
            if (link.mode_clk === 1'b1 && prev === 1'b0) begin
                chk("mode_bit", 16'(idx < 19 ? mode_word[idx] : 1'b0), 16'(link.mode_data));
                idx++;
            end
            prev = link.mode_clk;
        end
        wait_on(0, 1'b1, 1);
        cyc(4);
        chk("bit_count", 16'h0100, 16'(idx));
        chk("boot_done", 16'h0001, 16'(boot_done));
        chk("timer_dis", 16'h0001, 16'(timer_int_disabled));
        chk("in_reset", 16'h0000, 16'(in_reset));
        $display("test boot done");
        for (int i = 0; i < 7; i++) begin
            int_req = 6'((1 << i) & 6'h3F);
            nmi_req = (i == 6);
            cyc(4);
            chk("int_reg", 16'(1 << i), 16'(int_reg));
            chk("pins", 16'(~(1 << i) & 16'h007F), 16'({link.nmi_n, link.int_n}));
            int_req = 6'h00;
            nmi_req = 1'b0;
            cyc(4);
        end
        chk("int_clear", 16'h0000, 16'(int_reg));
        $display("test interrupts done");
        wait_exec = 1'b1;
        cyc(1);
        wait_exec = 1'b0;
        cyc(3);
        chk("busy_standby", 16'h0000, 16'(standby));
        chk("busy_clk_en", 16'h0001, 16'(core_clk_en));
        chk("int_enable", 16'h0001, 16'(int_enable));
        bus_idle = 1'b1;
        wait_exec = 1'b1;
        cyc(1);
        wait_exec = 1'b0;
        chk("standby", 16'h0001, 16'(standby));
        chk("clk_en", 16'h0000, 16'(core_clk_en));
        cyc(50);
        chk("still_standby", 16'h0001, 16'(standby));
        int_req = 6'h01;
        wait_on(1, 1'b0, 10);
        chk("wake_clk_en", 16'h0001, 16'(core_clk_en));
        chk("wake_int", 16'h0001, 16'(int_reg));
        int_req = 6'h00;
        $display("test standby done");
        for (int k = 0; k < 2; k++) begin
            {cold_req, warm_req} = (k == 0) ? 2'b01 : 2'b10;
            cyc(1);
            {cold_req, warm_req} = 2'b00;
            wait_on(2, 1'b1, 10);
            wait_on(0, 1'b1, 200);
            wait_on(2, 1'b0, 10);
            chk("int_en_reset", 16'h0000, 16'(int_enable));
        end
        $display("test resets done");
        stop_test();
    end
endmodule // reset_boot_standby_control_tb_top
`default_nettype wire
